// file: tb/gfc_counter_bench.sv
// Self-checking bench for gfc_counter over APB.
// Assumes gfc_pin_model as signal source and a shortened search step.
`timescale 1ns/100ps
`default_nettype none
module gfc_counter_bench;
   import gfc_pkg::*;
   localparam int SRCH = 20; // Shortened search step
   logic        mclk, rstn, psel, penable, pwrite, freqDetect, rateSwitch, lastErr;
   logic        tapOut, offFrequencyLed, gateLed, pready, pslverr, refIn, pls, tapPrev;
   logic [1:0]  rangeSwitch;
   logic [2:0]  liveCh;
   logic [5:0]  chanIn;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          err_count, n_checks, i, tgl, t0, cyc;
   gfc_counter #(.SEARCH_CYCLES(SRCH)) i_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .chanIn, .refIn, .phaseLockedPulseSource(pls),
      .freqDetect, .rangeSwitch, .rateSwitch, .tapOut, .offFrequencyLed, .gateLed);
   gfc_pin_model i_pins (.mclk, .rstn, .liveCh, .chanIn, .refIn, .pulse(pls));
   ////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Tap output activity and cycle count, both from reset release
   always @(posedge mclk) begin
      if (!rstn) begin
         tgl     <= 0;
         tapPrev <= 1'b0;
         cyc     <= 0;
      end else begin
         tgl     <= tgl + int'(tapOut !== tapPrev);
         tapPrev <= tapOut;
         cyc     <= cyc + 1;
      end
   end
   // One APB transfer, entered just after a rising edge; waits for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Poll status until the gate state matches
   task automatic wait_gate(input gfc_gate_t st);
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end while (rd[6:5] !== st && n < 10000);
      chk("gate state", 32'(rd[6:5]), 32'(st));
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #(60000 * 50);
      err_count++;
      give_verdict();
   end
   initial begin
      rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      freqDetect = 1'b1; rangeSwitch = 2'h0; rateSwitch = 1'b0; liveCh = 3'h2;
      err_count = 0;
      n_checks = 0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      // Registers, refusal and switches
      apb(1'b0, ADDR_CHSEL, 32'h0);
      chk("chsel reset", rd, 32'(CHSEL_RST));
      for (i = 3; i >= 0; i--) begin
         apb(1'b1, ADDR_TBSEL, 32'(i));
         apb(1'b0, ADDR_TBSEL, 32'h0);
         chk("tbsel", rd, 32'(i));
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped error", 32'(lastErr), 32'h1);
      chk("unmapped data", rd, 32'h0);
      for (i = 0; i < 8; i++) begin
         {rateSwitch, rangeSwitch} <= 3'(i);
         repeat (4) @(posedge mclk);
         apb(1'b0, ADDR_SWITCH, 32'h0);
         chk("switches", 32'(rd[2:0]), 32'(i));
      end
      $display("register test done");
      // Channel routing, host stepping the select
      for (i = 0; i < 6; i++) begin
         apb(1'b1, ADDR_CHSEL, 32'(i));
         repeat (10) @(posedge mclk);
         t0 = tgl;
         repeat (200) @(posedge mclk);
         chk("channel route", 32'(tgl != t0), 32'(i == 2));
      end
      $display("channel test done");
      // Tap search with wrap, then hold
      freqDetect <= 1'b0;
      repeat (10) @(posedge mclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("off flag", 32'(rd[0]), 32'h1);
      chk("off led", 32'(offFrequencyLed), 32'h1);
      for (i = 0; i < 5; i++) begin
         t0 = int'(rd[4:3]);
         repeat (SRCH - 3) @(posedge mclk);
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("tap step", 32'(rd[4:3]), 32'((t0 + 1) % 4));
      end
      freqDetect <= 1'b1;
      repeat (10) @(posedge mclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      t0 = int'(rd[4:3]);
      repeat (6 * SRCH) @(posedge mclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("tap held", 32'(rd[4:3]), 32'(t0));
      chk("on flag", 32'(rd[0]), 32'h0);
      // Held tap divides the live channel; its period is 8 cycles,
      // so 800 cycles hold 200 over the divide factor toggles
      i = (t0 == 0) ? 1 : (t0 == 1) ? 10 : (t0 == 2) ? 50 : 100;
      apb(1'b1, ADDR_CHSEL, 32'h2);
      repeat (10) @(posedge mclk);
      t0 = tgl;
      repeat (800) @(posedge mclk);
      chk("tap divide", 32'(tgl - t0), 32'(200 / i));
      $display("search test done");
      // Gate of 0.5 s: 5000 reference edges, pulses at the same rate
      apb(1'b0, ADDR_ACCLO, 32'h0);
      chk("idle count", rd, 32'h0);
      wait_gate(GS_OPEN);
      chk("gate opens", 32'(cyc >= 19900 && cyc <= 20200), 32'h1);
      chk("count led", 32'(gateLed), 32'h1);
      wait_gate(GS_HOLD);
      chk("led after close", 32'(gateLed), 32'h1);
      apb(1'b0, ADDR_ACCLO, 32'h0);
      repeat (100) @(posedge mclk);
      apb(1'b0, ADDR_ACCLO, 32'h0);
      chk("count low", rd, 32'h00005000);
      apb(1'b0, ADDR_ACCHI, 32'h0);
      chk("count high", rd, 32'h0);
      chk("led cleared", 32'(gateLed), 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("rearmed", 32'(rd[6:5]), 32'(GS_ARM));
      apb(1'b0, ADDR_ACCLO, 32'h0);
      chk("cleared count", rd, 32'h0);
      $display("gate test done");
      give_verdict();
   end
endmodule // gfc_counter_bench
bind gfc_counter gfc_counter_properties i_props (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .freqDetect, .offFrequencyLed, .gateLed);
`default_nettype wire

// file: tb/gfc_counter_properties.sv
// Checker for handshake and indicator timing of gfc_counter.
// Assumes it is bound to the top module ports on mclk.
`timescale 1ns/100ps
`default_nettype none
module gfc_counter_properties
   import gfc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        freqDetect,
   input wire logic        offFrequencyLed,
   input wire logic        gateLed
);
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire logic unmapped; // No register at this address
   wire logic hiRead;   // Clearing read completes
   assign unmapped = !(paddr inside {ADDR_CHSEL, ADDR_TBSEL, ADDR_STATUS, ADDR_ACCLO, ADDR_ACCHI, ADDR_SWITCH});
   assign hiRead = psel && penable && pready && !pwrite && (paddr == ADDR_ACCHI);
   // Bus phases
   sequence sSetup;
      psel && !penable;
   endsequence
   sequence sAccess;
      psel && penable && pready;
   endsequence
   ////////////////////////////////////////////////////////////
   a_setup_answer: assert property (sSetup |=> sAccess)
      else $error("setup not answered in next cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready high for two cycles");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_unmapped: assert property (pready |-> pslverr == unmapped)
      else $error("pslverr does not match decode");
   a_err_zero_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_offfreq_lit: assert property (!freqDetect [*5] |-> offFrequencyLed)
      else $error("off frequency indicator dark");
   a_offfreq_dark: assert property (freqDetect [*5] |-> !offFrequencyLed)
      else $error("off frequency indicator lit");
   a_led_off_cause: assert property ($fell(gateLed) |-> $past(hiRead))
      else $error("counting indicator fell without read");
   a_led_held: assert property (gateLed && !hiRead |=> gateLed)
      else $error("counting indicator dropped early");
   c_clear_read: cover property (sAccess ##0 hiRead);
endmodule // gfc_counter_properties
`default_nettype wire

// file: tb/gfc_pin_model.sv
// Model of the sources on the pin side of gfc_counter.
// Assumes mclk and rstn of the bench; all levels last two cycles or more.
`timescale 1ns/100ps
`default_nettype none
module gfc_pin_model (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [2:0] liveCh,
   output var  logic [5:0] chanIn,
   output var  logic       refIn,
   output var  logic       pulse
);
   logic [2:0] ph_r; // Phase of all waveforms
   // Reference and pulses both period 4, so counts per gate are exact
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ph_r   <= 3'h0;
         refIn  <= 1'b0;
         pulse  <= 1'b0;
         chanIn <= 6'h00;
      end else begin
         ph_r   <= ph_r + 3'h1;
         refIn  <= ph_r[1];
         pulse  <= ph_r[1] ^ ph_r[0];
         chanIn <= 6'(ph_r[2]) << liveCh; // Only one live channel
      end
   end
endmodule // gfc_pin_model
`default_nettype wire

// file: verilog/gfc_counter.sv
// Top of the gated frequency comparator counter.
// Assumes asynchronous pins, a 20 MHz mclk and an APB master.
// What this block does
// - Latched number routes one of six channels
// - Input divider taps by 1, 10, 50, 100
// - Detect low: 30 Hz tick steps tap
// - Detect high stops stepping, holds tap
// - Detect low lights off-frequency, flags host
// - Reference divided by 500 gives 20 Hz
// - Gate divider 10 to 10000 of 20 Hz
// - Host time-base select picks matching period
// - Gate opens on period edge, one period
// - Twelve BCD digits count gated pulses
// - Half second exact gate counts 1e8
// - Read strobe presents then clears accumulator
// - Read strobe extinguishes counting indicator once gate closed
// - Host reads digits, range and rate switches
// - Counting indicator lit while gate open
`timescale 1ns/100ps
`default_nettype none
module gfc_counter
   import gfc_pkg::*;
#(
   parameter int unsigned SEARCH_CYCLES = SEARCH_CYC
)(
   input  wire logic                mclk,
   input  wire logic                rstn,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output var  logic [31:0]         prdata,
   output var  logic                pready,
   output var  logic                pslverr,
   // Pins
   input  wire logic [NUM_CHAN-1:0] chanIn,
   input  wire logic                refIn,
   input  wire logic                phaseLockedPulseSource,
   input  wire logic                freqDetect,
   input  wire logic [1:0]          rangeSwitch,
   input  wire logic                rateSwitch,
   output var  logic                tapOut,
   output var  logic                offFrequencyLed,
   output var  logic                gateLed
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   gfc_pins_t pinsMeta_r;   // First stage, read only by second
   gfc_pins_t pins_r;       // Second stage, safe to use
   gfc_pins_t pinsDly_r;    // Delayed copy for edge detect
   gfc_pins_t pinsRaw;      // Bundle of raw pins

   assign pinsRaw = '{chan: chanIn, ref10: refIn, pulse: phaseLockedPulseSource,
                      freqDet: freqDetect, rangeSw: rangeSwitch, rateSw: rateSwitch};

   // Two flops then an edge-detect stage
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pinsMeta_r <= '0;
         pins_r     <= '0;
         pinsDly_r  <= '0;
      end else begin
         pinsMeta_r <= pinsRaw;
         pins_r     <= pinsMeta_r;
         pinsDly_r  <= pins_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   logic [2:0]  chSel_r;        // Channel select latch
   logic [1:0]  tbSel_r;        // Time base select
   logic [15:0] accHold_r;      // High digits caught at low read
   logic [47:0] accDigits;      // All twelve digits
   gfc_status_t status;         // Status word
   logic        setupPh;        // Setup cycle
   logic        apbDone;        // Completing access
   logic        hitChSel;       // Address hits
   logic        hitTbSel;
   logic        hitStatus;
   logic        hitAccLo;
   logic        hitAccHi;
   logic        hitSwitch;
   logic        hitAny;
   logic [31:0] rdMux;          // Read data select
   logic        readClearStrobeN; // Active low clear strobe

   assign setupPh   = psel & ~penable;
   assign apbDone   = psel & penable & pready;
   assign hitChSel  = (paddr == ADDR_CHSEL);
   assign hitTbSel  = (paddr == ADDR_TBSEL);
   assign hitStatus = (paddr == ADDR_STATUS);
   assign hitAccLo  = (paddr == ADDR_ACCLO);
   assign hitAccHi  = (paddr == ADDR_ACCHI);
   assign hitSwitch = (paddr == ADDR_SWITCH);
   assign hitAny    = hitChSel | hitTbSel | hitStatus | hitAccLo | hitAccHi | hitSwitch;
   // Strobe fires when a read of the high digits completes
   assign readClearStrobeN = ~(apbDone & ~pwrite & hitAccHi);

   // Read data select
   assign rdMux = hitChSel  ? {29'h0, chSel_r} :
                  hitTbSel  ? {30'h0, tbSel_r} :
                  hitStatus ? {25'h0, status} :
                  hitAccLo  ? accDigits[31:0] :
                  hitAccHi  ? {16'h0, accHold_r} :
                  hitSwitch ? {29'h0, pins_r.rateSw, pins_r.rangeSw} :
                  32'h0;

   // Answer one cycle after setup
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setupPh;
         prdata  <= setupPh ? rdMux : prdata;
         pslverr <= setupPh & ~hitAny;
      end
   end

   // Writable registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         chSel_r <= CHSEL_RST;
         tbSel_r <= TBSEL_RST;
      end else begin
         if (apbDone & pwrite & hitChSel) begin
            chSel_r <= pwdata[2:0];
         end
         if (apbDone & pwrite & hitTbSel) begin
            tbSel_r <= pwdata[1:0];
         end
      end
   end

   // Snapshot of high digits taken with the low read
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         accHold_r <= 16'h0;
      end else if (setupPh & ~pwrite & hitAccLo) begin
         accHold_r <= accDigits[47:32];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel routing and input divider
   logic       chanLvl;        // Selected channel level
   logic       chanLvlDly;     // Its delayed copy
   logic       chanEdge;       // Rising edge of selected channel
   logic [5:0] cnt10_r;        // Half period counters
   logic [5:0] cnt50_r;
   logic [5:0] cnt100_r;
   logic       div10_r;        // Divided outputs
   logic       div50_r;
   logic       div100_r;
   logic       tapMux;         // Tap multiplexer output

   // Channel numbers above six read as no signal
   assign chanLvl    = (chSel_r < 3'(NUM_CHAN)) ? pins_r.chan[chSel_r] : 1'b0;
   assign chanLvlDly = (chSel_r < 3'(NUM_CHAN)) ? pinsDly_r.chan[chSel_r] : 1'b0;
   assign chanEdge   = chanLvl & ~chanLvlDly;

   // Toggle dividers on selected edges
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt10_r  <= 6'h0;
         cnt50_r  <= 6'h0;
         cnt100_r <= 6'h0;
         div10_r  <= 1'b0;
         div50_r  <= 1'b0;
         div100_r <= 1'b0;
      end else if (chanEdge) begin
         cnt10_r  <= (cnt10_r == HALF_DIV10) ? 6'h0 : cnt10_r + 6'h1;
         cnt50_r  <= (cnt50_r == HALF_DIV50) ? 6'h0 : cnt50_r + 6'h1;
         cnt100_r <= (cnt100_r == HALF_DIV100) ? 6'h0 : cnt100_r + 6'h1;
         div10_r  <= div10_r ^ (cnt10_r == HALF_DIV10);
         div50_r  <= div50_r ^ (cnt50_r == HALF_DIV50);
         div100_r <= div100_r ^ (cnt100_r == HALF_DIV100);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tap search
   gfc_tap_t   tapSel_r;       // Tap select counter
   logic [19:0] searchCnt_r;   // 30 Hz tick divider
   logic       searchTick;     // Search tick
   logic       offFreq;        // Detect low

   assign offFreq    = ~pins_r.freqDet;
   assign searchTick = offFreq & (searchCnt_r == 20'(SEARCH_CYCLES - 1));
   assign tapMux     = (tapSel_r == TAP_DIV1)  ? chanLvl :
                       (tapSel_r == TAP_DIV10) ? div10_r :
                       (tapSel_r == TAP_DIV50) ? div50_r : div100_r;

   // Tick runs only while off frequency
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         searchCnt_r <= 20'h0;
         tapSel_r    <= TAP_DIV1;
      end else if (offFreq) begin
         searchCnt_r <= searchTick ? 20'h0 : searchCnt_r + 20'h1;
         tapSel_r    <= searchTick ? gfc_tap_t'(tapSel_r + 2'h1) : tapSel_r;
      end else begin
         searchCnt_r <= 20'h0;
      end
   end

   // Tap and off-frequency outputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tapOut          <= 1'b0;
         offFrequencyLed <= 1'b0;
      end else begin
         tapOut          <= tapMux;
         offFrequencyLed <= offFreq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference divider and gate divider
   logic [8:0] refCnt_r;            // Divide by 500 counter
   logic       refEdge;             // Reference rising edge
   logic       tick20;              // 20 Hz tick
   logic [NUM_GATE_DEC:0] gateInc;  // Decade chain carries
   logic [4*NUM_GATE_DEC-1:0] gateDigits; // Gate divider digits
   logic       periodTick;          // Leading edge of selected period

   assign refEdge = pins_r.ref10 & ~pinsDly_r.ref10;
   assign tick20  = refEdge & (refCnt_r == REF_DIV_LAST);
   assign gateInc[0] = tick20;

   // Reference count modulo 500
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         refCnt_r <= 9'h0;
      end else if (refEdge) begin
         refCnt_r <= tick20 ? 9'h0 : refCnt_r + 9'h1;
      end
   end

   // Four decades give divide by 10 to 10000
   genvar g;
   generate
      for (g = 0; g < NUM_GATE_DEC; g++) begin : gGate
         gfc_decade uDec (
            .mclk  (mclk),
            .rstn  (rstn),
            .inc   (gateInc[g]),
            .clr   (1'b0),
            .digit (gateDigits[4*g +: 4]),
            .carry (gateInc[g+1])
         );
      end
   endgenerate

   // Time base select picks one period
   assign periodTick = gateInc[tbSel_r + 3'h1];

   ////////////////////////////////////////////////////////////////////////////
   // Gate control and counting indicator
   gfc_gate_t gateSt_r;    // Gate state
   gfc_gate_t gateSt_nxt;  // Next gate state
   logic      gateOpen;    // Pulse gate enabled
   logic      countLed_nxt; // Next indicator value

   assign gateOpen = (gateSt_r == GS_OPEN);

   // Open on one period edge, close on the next
   always_comb begin
      gateSt_nxt = gateSt_r;
      case (gateSt_r)
         GS_ARM: begin
            if (periodTick) begin
               gateSt_nxt = GS_OPEN;
            end
         end
         GS_OPEN: begin
            if (periodTick) begin
               gateSt_nxt = GS_HOLD;
            end
         end
         GS_HOLD: begin
            if (!readClearStrobeN) begin
               gateSt_nxt = GS_ARM;
            end
         end
         default: begin
            gateSt_nxt = GS_ARM;
         end
      endcase
   end

   // Lit while open; strobe only clears it once closed
   assign countLed_nxt = gateOpen | (gateLed & readClearStrobeN);

   // Gate state and indicator
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         gateSt_r <= GS_ARM;
         gateLed  <= 1'b0;
      end else begin
         gateSt_r <= gateSt_nxt;
         gateLed  <= countLed_nxt;
      end
   end

   assign status = '{gateState: gateSt_r, tap: tapSel_r, countLed: gateLed,
                     gateOpen: gateOpen, offFreq: offFreq};

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator
   logic [NUM_DIGITS:0] accInc;  // Digit carries
   logic                pulseEdge; // Pulse rising edge

   assign pulseEdge = pins_r.pulse & ~pinsDly_r.pulse;
   assign accInc[0] = pulseEdge & gateOpen;

   // Twelve BCD digits, 1e8 fits in nine of them
   generate
      for (g = 0; g < NUM_DIGITS; g++) begin : gAcc
         gfc_decade uDec (
            .mclk  (mclk),
            .rstn  (rstn),
            .inc   (accInc[g]),
            .clr   (~readClearStrobeN),
            .digit (accDigits[4*g +: 4]),
            .carry (accInc[g+1])
         );
      end
   endgenerate
endmodule // gfc_counter
`default_nettype wire

// file: verilog/gfc_decade.sv
// One BCD decade counter with carry.
// Assumes inc and clr come from logic on mclk.
`timescale 1ns/100ps
`default_nettype none
module gfc_decade
   import gfc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       inc,
   input  wire logic       clr,
   output var  logic [3:0] digit,
   output wire logic       carry
);
   logic [3:0] digit_nxt;  // Next digit value

   // Wrap at nine, carry out on the wrap
   assign carry = inc & (digit == DIGIT_MAX);
   // Clear loses no incoming count
   assign digit_nxt = clr ? {3'h0, inc} : (carry ? 4'h0 : digit + {3'h0, inc});

   // Digit register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         digit <= 4'h0;
      end else begin
         digit <= digit_nxt;
      end
   end
endmodule // gfc_decade
`default_nettype wire

// file: verilog/gfc_pkg.sv
// Package for the gated frequency comparator counter.
// Assumes a 20 MHz mclk and an APB slave with 32-bit data.
package gfc_pkg;
   // Clock and search tick timing
   localparam int unsigned CLK_HZ        = 20000000;          // mclk rate in Hz
   localparam int unsigned SEARCH_HZ     = 30;                // Tap search tick in Hz
   localparam int unsigned SEARCH_CYC    = CLK_HZ / SEARCH_HZ; // Cycles per search tick
   // Reference and gate dividers
   localparam logic [8:0]  REF_DIV_LAST  = 9'h1f3;            // Divide by 500, last count
   localparam logic [3:0]  DIGIT_MAX     = 4'h9;              // Top value of a decade digit
   localparam int unsigned NUM_DIGITS    = 12;                // Accumulator digits
   localparam int unsigned NUM_GATE_DEC  = 4;                 // Gate divider decades
   localparam int unsigned NUM_CHAN      = 6;                 // Input channels
   // Input divider half period last counts (toggle every N+1 selected edges)
   localparam logic [5:0]  HALF_DIV10    = 6'h04;             // Toggle after 5 edges
   localparam logic [5:0]  HALF_DIV50    = 6'h18;             // Toggle after 25 edges
   localparam logic [5:0]  HALF_DIV100   = 6'h31;             // Toggle after 50 edges
   // Register byte addresses
   localparam logic [7:0]  ADDR_CHSEL    = 8'h00;             // Channel select latch
   localparam logic [7:0]  ADDR_TBSEL    = 8'h04;             // Time base select
   localparam logic [7:0]  ADDR_STATUS   = 8'h08;             // Status
   localparam logic [7:0]  ADDR_ACCLO    = 8'h0c;             // Digits 7..0
   localparam logic [7:0]  ADDR_ACCHI    = 8'h10;             // Digits 11..8, read clears
   localparam logic [7:0]  ADDR_SWITCH   = 8'h14;             // Panel switches
   // Reset values
   localparam logic [2:0]  CHSEL_RST     = 3'h0;              // Channel 1
   localparam logic [1:0]  TBSEL_RST     = 2'h0;              // 0.5 s gate
   // Tap codes
   typedef enum logic [1:0] {
      TAP_DIV1   = 2'b00,
      TAP_DIV10  = 2'b01,
      TAP_DIV50  = 2'b10,
      TAP_DIV100 = 2'b11
   } gfc_tap_t;
   // Gate states
   typedef enum logic [1:0] {
      GS_ARM  = 2'b00,
      GS_OPEN = 2'b01,
      GS_HOLD = 2'b10
   } gfc_gate_t;
   // Status word fields
   typedef struct packed {
      gfc_gate_t gateState;   // Gate state
      gfc_tap_t  tap;         // Current tap
      logic      countLed;    // Counting indicator
      logic      gateOpen;    // Pulse gate enabled
      logic      offFreq;     // Off-frequency flag
   } gfc_status_t;
   // Synchronised pin bundle
   typedef struct packed {
      logic [NUM_CHAN-1:0] chan;      // Channel inputs
      logic                ref10;     // 10 kHz reference
      logic                pulse;     // Phase locked pulses
      logic                freqDet;   // Frequency detect comparator
      logic [1:0]          rangeSw;   // Resolution switch
      logic                rateSw;    // Sample rate switch
   } gfc_pins_t;
endpackage
